// File: shared/dialer_pkg.sv
// Constants, register map and carrier types for the dialer control block
package dialer_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef logic [DATA_W-1:0] nib_t;

    localparam logic [ADDR_W-1:0] MODE_ADDR = 16'hFF10;
    localparam logic [ADDR_W-1:0] PAUSE_ADDR = 16'hFF11;
    localparam logic [ADDR_W-1:0] BREAK_ADDR = 16'hFF12;
    localparam logic [ADDR_W-1:0] PINSEL_ADDR = 16'hFF13;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'hFF14;
    localparam logic [ADDR_W-1:0] GAP_ADDR = 16'hFF15;
    localparam logic [ADDR_W-1:0] TONE_ADDR = 16'hFF16;
    localparam logic [ADDR_W-1:0] HOOK_ADDR = 16'hFF18;
    localparam logic [ADDR_W-1:0] PORT_DATA_ADDR = 16'hFF32;
    localparam logic [ADDR_W-1:0] PORT_HIZ_ADDR = 16'hFF33;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 16'hFFE9;
    localparam logic [ADDR_W-1:0] IRQ_FLAG_ADDR = 16'hFFF9;

    // Field positions
    localparam int MODE_PULSE_BIT = 3;
    localparam int MODE_MB_BIT = 1;
    localparam int MODE_DRS_BIT = 0;
    localparam int PINSEL_KEEP_BIT = 2;
    localparam int CTRL_HF_BIT = 3;
    localparam int CTRL_HOLD_BIT = 2;
    localparam int CTRL_PAUSE_BIT = 1;
    localparam int CTRL_FLASH_BIT = 0;
    localparam int TONE_CTO_BIT = 3;
    localparam int HOOK_ON_BIT = 3;
    localparam int PORT_TWO_BIT = 2;
    localparam int IRQ_BIT = 0;

    // Reset values and writable masks
    localparam nib_t MODE_RST = 4'h0;
    localparam nib_t MODE_RW_MASK = 4'hB;
    localparam nib_t PAUSE_RST = 4'h4;
    localparam nib_t BREAK_RST = 4'h6;
    localparam nib_t PINSEL_RST = 4'h0;
    localparam nib_t GAP_RST = 4'h8;
    localparam nib_t TONE_RST = 4'h3;
    localparam nib_t HOOK_RST = 4'h3;
    localparam nib_t HOOK_RW_MASK = 4'hB;
    localparam nib_t PORT_DATA_RST = 4'hF;
    localparam nib_t PORT_HIZ_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: one low-speed tick every 31.25 ms
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_US = 31250;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int STEP_US = 93750;
    localparam int FLASH_REST_MS = 938;
    localparam int TONE_GAP_MS = 94;
    localparam int PAUSE_STEP_MS = 1000;

    localparam int CNT_W = 9;
    typedef logic [CNT_W-1:0] cnt_t;

    localparam cnt_t STEP_TICKS = cnt_t'(STEP_US / TICK_US);
    localparam cnt_t FLASH_REST_TICKS = cnt_t'(FLASH_REST_MS * 1000 / TICK_US);
    localparam cnt_t TONE_GAP_TICKS = cnt_t'(TONE_GAP_MS * 1000 / TICK_US);
    localparam cnt_t PAUSE_STEP_TICKS = cnt_t'(PAUSE_STEP_MS * 1000 / TICK_US);

    ////////////////////////////////////////////////////////////////////////////
    // Timer channels and flash sequence
    localparam int NUM_CH = 3;
    localparam int CH_FLASH = 0;
    localparam int CH_PAUSE = 1;
    localparam int CH_DIAL = 2;

    typedef enum logic [2:0] {
        FL_IDLE = 3'b001,
        FL_BREAK = 3'b010,
        FL_REST = 3'b100
    } flash_state_e;

endpackage : dialer_pkg

// File: hdl/tick_divider.sv
// Divider that turns the system clock into the low-speed tick enable
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = 3125000
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    output logic tick_out
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (cnt_ff == LAST);
            cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
        end
    end

    assign tick_out = tick_ff;

endmodule : tick_divider

// File: hdl/span_timer.sv
// Tick-based down counter: loads a span, pulses done when it runs out
`timescale 1ns/1ps
module span_timer #(
    parameter int W = 9
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic [W-1:0] load_in,
    output logic busy_out,
    output logic done_out
);
    logic [W-1:0] count_ff;
    logic done_ff;

    // A restart wins over a tick; the first tick may be a partial one
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= !start_in && tick_in && (count_ff == W'(1));
            if (start_in)
                count_ff <= load_in;
            else if (tick_in && count_ff != '0)
                count_ff <= count_ff - 1'b1;
        end
    end

    assign busy_out = (count_ff != '0);
    assign done_out = done_ff;

endmodule : span_timer

// File: hdl/dialer_control.sv
// Dialer flash, hold-line and completion interrupt control
// Summary of operation
// - Flash drives line pulse low for coded time
// - Flash duration resets to 563 ms code
// - Only the flash trigger bit starts a flash
// - Flash trigger is write-only, start only
// - Fixed 938 ms rest, then interrupt
// - Flash trigger self-clears at flash interrupt
// - Hold bit drives transmit silence low
// - Keep status on pin two follows hold
// - Pin two data low forces status low
// - Tone mode: 94 ms gap, then interrupt
// - Pulse mode: programmed gap, then interrupt
// - Pause trigger: programmed seconds, then interrupt
// - Flag always set; mask gates CPU request
// - Flag sets even while masked
// - Writing one clears the flag
// - Mode bit selects pulse; bit two reads zero
// - Make/break select resets to 40:60
// - Pulse rate select resets to 10pps
// - Pause duration resets to 4 seconds
// - Digit gap resets to 750 ms code
// - Pause trigger self-clears at pause interrupt
// - Hook switch on drives line pulse high
`timescale 1ns/1ps
module dialer_control
    import dialer_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire bus_req_s bus_req_in,
    input wire logic tone_end_in,
    input wire logic pulse_end_in,
    output logic [DATA_W-1:0] rd_data_out,
    output logic line_pulse_n_out,
    output logic transmit_silence_n_out,
    output logic port_pin_two_out,
    output logic port_pin_two_oe_n_out,
    output logic pulse_mode_out,
    output logic make_break_select_out,
    output logic pulse_rate_select_out,
    output logic continuous_tone_bit_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    nib_t mode_ff;
    nib_t gap_duration_select_ff;
    nib_t line_break_duration_ff;
    nib_t pinsel_ff;
    nib_t digit_gap_select_ff;
    nib_t tone_ff;
    nib_t hook_ff;
    nib_t port_data_ff;
    nib_t port_hiz_ff;
    nib_t rd_data_ff;
    nib_t rd_mux;
    logic hf_ff;
    logic hold_ff;
    logic pause_bit_ff;
    logic flash_bit_ff;
    logic dialer_irq_flag_ff;
    logic dialer_irq_mask_ff;
    logic irq_ff;
    logic line_pulse_n_ff;
    logic silence_n_ff;
    logic pin_two_ff;
    logic pin_two_oe_n_ff;
    flash_state_e flash_state_ff;
    logic tick;
    logic [NUM_CH-1:0] start_vec;
    logic [NUM_CH-1:0] busy_vec;
    logic [NUM_CH-1:0] done_vec;
    cnt_t load_vec [NUM_CH];
    logic ctrl_wr;
    logic flash_go;
    logic pause_go;
    logic tone_go;
    logic pulse_go;
    logic irq_event;
    logic flag_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign ctrl_wr = bus_req_in.wr && (bus_req_in.addr == CTRL_ADDR);
    assign flag_clr = bus_req_in.wr && (bus_req_in.addr == IRQ_FLAG_ADDR)
        && bus_req_in.wdata[IRQ_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mode_ff <= MODE_RST;
            gap_duration_select_ff <= PAUSE_RST;
            line_break_duration_ff <= BREAK_RST;
            pinsel_ff <= PINSEL_RST;
            digit_gap_select_ff <= GAP_RST;
            tone_ff <= TONE_RST;
            hook_ff <= HOOK_RST;
            port_data_ff <= PORT_DATA_RST;
            port_hiz_ff <= PORT_HIZ_RST;
            dialer_irq_mask_ff <= 1'b0;
            hf_ff <= 1'b0;
            hold_ff <= 1'b0;
        end
        else if (bus_req_in.wr)
        begin
            unique case (bus_req_in.addr)
                MODE_ADDR: mode_ff <= bus_req_in.wdata & MODE_RW_MASK;
                PAUSE_ADDR: gap_duration_select_ff <= bus_req_in.wdata;
                BREAK_ADDR: line_break_duration_ff <= bus_req_in.wdata;
                PINSEL_ADDR: pinsel_ff <= bus_req_in.wdata;
                CTRL_ADDR:
                begin
                    hf_ff <= bus_req_in.wdata[CTRL_HF_BIT];
                    hold_ff <= bus_req_in.wdata[CTRL_HOLD_BIT];
                end
                GAP_ADDR: digit_gap_select_ff <= bus_req_in.wdata;
                TONE_ADDR: tone_ff <= bus_req_in.wdata;
                HOOK_ADDR: hook_ff <= bus_req_in.wdata & HOOK_RW_MASK;
                PORT_DATA_ADDR: port_data_ff <= bus_req_in.wdata;
                PORT_HIZ_ADDR: port_hiz_ff <= bus_req_in.wdata;
                IRQ_MASK_ADDR: dialer_irq_mask_ff <= bus_req_in.wdata[IRQ_BIT];
                default:
                begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data stand for one cycle, unmapped reads give zero
    always_comb
    begin
        unique case (bus_req_in.addr)
            MODE_ADDR: rd_mux = mode_ff;
            PAUSE_ADDR: rd_mux = gap_duration_select_ff;
            BREAK_ADDR: rd_mux = line_break_duration_ff;
            PINSEL_ADDR: rd_mux = pinsel_ff;
            CTRL_ADDR: rd_mux = {hf_ff, hold_ff, 2'h0};
            GAP_ADDR: rd_mux = digit_gap_select_ff;
            TONE_ADDR: rd_mux = tone_ff;
            HOOK_ADDR: rd_mux = hook_ff;
            PORT_DATA_ADDR: rd_mux = port_data_ff;
            PORT_HIZ_ADDR: rd_mux = port_hiz_ff;
            IRQ_MASK_ADDR: rd_mux = {3'h0, dialer_irq_mask_ff};
            IRQ_FLAG_ADDR: rd_mux = {3'h0, dialer_irq_flag_ff};
            default: rd_mux = 4'h0;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            rd_data_ff <= 4'h0;
        else
            rd_data_ff <= bus_req_in.rd ? rd_mux : 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-speed tick and the three span timers
    tick_divider #(
        .DIV(TICK_DIV)
    ) u_tick (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .tick_out(tick)
    );

    // A zero duration code would load an empty span and hang the sequence
    assign flash_go = ctrl_wr && bus_req_in.wdata[CTRL_FLASH_BIT]
        && (flash_state_ff == FL_IDLE);
    assign pause_go = ctrl_wr && bus_req_in.wdata[CTRL_PAUSE_BIT]
        && !pause_bit_ff;
    assign tone_go = tone_end_in && !mode_ff[MODE_PULSE_BIT];
    assign pulse_go = pulse_end_in && mode_ff[MODE_PULSE_BIT];

    always_comb
    begin
        start_vec[CH_FLASH] = flash_go
            || (flash_state_ff == FL_BREAK && done_vec[CH_FLASH]);
        load_vec[CH_FLASH] = (flash_state_ff == FL_IDLE)
            ? cnt_t'(line_break_duration_ff) * STEP_TICKS
            : FLASH_REST_TICKS;
        start_vec[CH_PAUSE] = pause_go;
        load_vec[CH_PAUSE] = cnt_t'(gap_duration_select_ff) * PAUSE_STEP_TICKS;
        start_vec[CH_DIAL] = tone_go || pulse_go;
        load_vec[CH_DIAL] = pulse_go
            ? cnt_t'(digit_gap_select_ff) * STEP_TICKS
            : TONE_GAP_TICKS;
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_timer
            span_timer #(
                .W(CNT_W)
            ) u_span (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .tick_in(tick),
                .start_in(start_vec[ch]),
                .load_in(load_vec[ch]),
                .busy_out(busy_vec[ch]),
                .done_out(done_vec[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Flash sequence: break, fixed rest, then completion
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flash_state_ff <= FL_IDLE;
            flash_bit_ff <= 1'b0;
        end
        else
        begin
            unique case (flash_state_ff)
                FL_IDLE:
                    if (flash_go)
                    begin
                        flash_state_ff <= FL_BREAK;
                        flash_bit_ff <= 1'b1;
                    end
                FL_BREAK:
                    if (done_vec[CH_FLASH])
                        flash_state_ff <= FL_REST;
                FL_REST:
                    if (done_vec[CH_FLASH])
                    begin
                        flash_state_ff <= FL_IDLE;
                        flash_bit_ff <= 1'b0;
                    end
                default:
                begin
                    flash_state_ff <= FL_IDLE;
                    flash_bit_ff <= 1'b0;
                end
            endcase
        end
    end

    // Pause trigger stays set until its own completion
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            pause_bit_ff <= 1'b0;
        else if (done_vec[CH_PAUSE])
            pause_bit_ff <= 1'b0;
        else if (pause_go)
            pause_bit_ff <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared completion flag; an event in the clearing cycle is kept
    assign irq_event = (flash_state_ff == FL_REST && done_vec[CH_FLASH])
        || done_vec[CH_PAUSE] || done_vec[CH_DIAL];

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            dialer_irq_flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            dialer_irq_flag_ff <= irq_event
                || (dialer_irq_flag_ff && !flag_clr);
            irq_ff <= dialer_irq_flag_ff && dialer_irq_mask_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line side outputs
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            line_pulse_n_ff <= 1'b0;
            silence_n_ff <= 1'b1;
            pin_two_ff <= 1'b1;
            pin_two_oe_n_ff <= 1'b0;
        end
        else
        begin
            line_pulse_n_ff <= hook_ff[HOOK_ON_BIT]
                && (flash_state_ff != FL_BREAK);
            silence_n_ff <= !hold_ff;
            // Pin data low wins, so the status can never float high
            pin_two_ff <= port_data_ff[PORT_TWO_BIT]
                && (!pinsel_ff[PINSEL_KEEP_BIT] || hold_ff);
            pin_two_oe_n_ff <= port_hiz_ff[PORT_TWO_BIT];
        end
    end

    assign rd_data_out = rd_data_ff;
    assign line_pulse_n_out = line_pulse_n_ff;
    assign transmit_silence_n_out = silence_n_ff;
    assign port_pin_two_out = pin_two_ff;
    assign port_pin_two_oe_n_out = pin_two_oe_n_ff;
    assign pulse_mode_out = mode_ff[MODE_PULSE_BIT];
    assign make_break_select_out = mode_ff[MODE_MB_BIT];
    assign pulse_rate_select_out = mode_ff[MODE_DRS_BIT];
    assign continuous_tone_bit_out = tone_ff[TONE_CTO_BIT];
    assign irq_out = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence flash_req_s;
        flash_go && hook_ff[HOOK_ON_BIT];
    endsequence

    sequence break_low_s;
        (flash_state_ff == FL_BREAK) ##1 !line_pulse_n_out;
    endsequence

    flash_start_a: assert property (flash_req_s |=> break_low_s)
        else $error("flash did not pull the line pulse low");

    duration_write_a: assert property (
        bus_req_in.wr && bus_req_in.addr == BREAK_ADDR && flash_state_ff == FL_IDLE
        && !flash_go |=> flash_state_ff == FL_IDLE)
        else $error("duration write started a flash");

    flash_end_a: assert property (
        flash_state_ff == FL_REST && done_vec[CH_FLASH]
        |=> dialer_irq_flag_ff && flash_state_ff == FL_IDLE)
        else $error("flash completion did not set the flag");

    flash_clear_a: assert property (
        $fell(flash_bit_ff) |-> $past(flash_state_ff) == FL_REST && dialer_irq_flag_ff)
        else $error("flash trigger cleared at the wrong time");

    pause_clear_a: assert property (
        done_vec[CH_PAUSE] |=> !pause_bit_ff && dialer_irq_flag_ff)
        else $error("pause trigger not cleared at completion");

    hold_mute_a: assert property (
        ctrl_wr && bus_req_in.wdata[CTRL_HOLD_BIT] |=> ##1 !transmit_silence_n_out)
        else $error("hold did not silence transmit");

    keep_low_a: assert property (
        !port_data_ff[PORT_TWO_BIT] |=> !port_pin_two_out)
        else $error("keep status high with pin data low");

    keep_follow_a: assert property (
        pinsel_ff[PINSEL_KEEP_BIT] && port_data_ff[PORT_TWO_BIT]
        |=> port_pin_two_out == $past(hold_ff))
        else $error("keep status does not follow hold");

    flag_masked_a: assert property (
        irq_event && !dialer_irq_mask_ff
        |=> dialer_irq_flag_ff ##1 (irq_out == $past(dialer_irq_mask_ff)))
        else $error("masked event lost or forwarded");

    flag_clear_a: assert property (
        flag_clr && !irq_event |=> !dialer_irq_flag_ff)
        else $error("flag not cleared by writing one");

    mode_read_a: assert property (
        bus_req_in.rd && bus_req_in.addr == MODE_ADDR |=> rd_data_out[2] == 1'b0)
        else $error("unused mode bit reads as one");

    tone_gap_a: assert property (
        tone_go |=> busy_vec[CH_DIAL] && !done_vec[CH_DIAL])
        else $error("tone gap not started");

endmodule : dialer_control

// File: tb/line_model.sv
// Line interface model: times line breaks and reports digit ends
`timescale 1ns/1ps
module line_model (
    input wire logic sys_clk_in,
    input wire logic line_pulse_n_in,
    output logic tone_end_out,
    output logic pulse_end_out
);
    int low_cnt = 0;
    int break_len = 0;

    initial
    begin
        tone_end_out = 1'b0;
        pulse_end_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Width of the last low period, latched as the line is released
    always @(posedge sys_clk_in)
    begin
        if (line_pulse_n_in === 1'b0)
            low_cnt <= low_cnt + 1;
        else if (low_cnt != 0)
        begin
            break_len <= low_cnt;
            low_cnt <= 0;
        end
    end

    // One-cycle end-of-digit pulse, as the tone or pulse source would give
    task automatic end_digit(input bit pulse);
        @(posedge sys_clk_in);
        tone_end_out <= !pulse;
        pulse_end_out <= pulse;
        @(posedge sys_clk_in);
        tone_end_out <= 1'b0;
        pulse_end_out <= 1'b0;
    endtask : end_digit
endmodule : line_model

// File: tb/dialer_control_tb_top.sv
// Register-level testbench for the dialer control block
`timescale 1ns/1ps
module dialer_control_tb_top;
    import dialer_pkg::*;
    logic sys_clk;
    logic rst;
    bus_req_s req;
    logic tone_end, pulse_end, line_n, silence_n, pin_two, pin_oe_n, irq;
    logic pmode, mbs, prs, continuous_tone_bit;
    nib_t rdata;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [15:0] rst_a[8] = '{MODE_ADDR, PAUSE_ADDR, BREAK_ADDR, GAP_ADDR, CTRL_ADDR,
        IRQ_FLAG_ADDR, IRQ_MASK_ADDR, 16'hFF40};
    nib_t rst_v[8] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
    nib_t codes[2] = '{4'h1, 4'hF};

    // Short tick keeps a 1.4 s flash within a few hundred cycles
    dialer_control #(.TICK_DIV(10)) DUT (.sys_clk_in(sys_clk), .rst_in(rst),
        .bus_req_in(req), .tone_end_in(tone_end), .pulse_end_in(pulse_end),
        .rd_data_out(rdata), .line_pulse_n_out(line_n), .transmit_silence_n_out(silence_n),
        .port_pin_two_out(pin_two), .port_pin_two_oe_n_out(pin_oe_n),
        .pulse_mode_out(pmode), .make_break_select_out(mbs),
        .pulse_rate_select_out(prs), .continuous_tone_bit_out(continuous_tone_bit), .irq_out(irq));
    line_model PARTNER (.sys_clk_in(sys_clk), .line_pulse_n_in(line_n),
        .tone_end_out(tone_end), .pulse_end_out(pulse_end));

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string n, input int lo, input int hi, input int g);
        n_tests++;
        if (g < lo || g > hi)
        begin
            miscompares++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chk_rng

    task automatic wr(input logic [15:0] a, input nib_t d);
        @(posedge sys_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string n, input logic [15:0] a, input nib_t e);
        @(posedge sys_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask : rchk

    task automatic wait_irq(input string n, input int lo, input int hi);
        int c;
        c = 0;
        while (irq !== 1'b1 && c < 2000)
        begin
            @(posedge sys_clk);
            #1 c++;
        end
        chk_rng(n, lo, hi, c);
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        req = '0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rst_a[i]) rchk("reset value", rst_a[i], rst_v[i]);
        chk("line on hook", 4'h0, {3'h0, line_n});
        chk("outputs after reset", 4'h0, {continuous_tone_bit, pmode, mbs, prs});
        $display("reset values done");

        wr(MODE_ADDR, 4'hF);
        wr(TONE_ADDR, 4'h8);
        rchk("mode readback", MODE_ADDR, 4'hB);
        chk("mode outputs", 4'hF, {continuous_tone_bit, pmode, mbs, prs});
        wr(MODE_ADDR, 4'h0);
        $display("mode test done");

        wr(HOOK_ADDR, 4'hB);
        repeat (2) @(posedge sys_clk);
        #1 chk("line off hook", 4'h1, {3'h0, line_n});
        wr(IRQ_MASK_ADDR, 4'h1);
        wr(BREAK_ADDR, 4'h1);
        repeat (40) @(posedge sys_clk);
        #1 chk("no flash on duration write", 4'h1, {3'h0, line_n});
        foreach (codes[i])
        begin
            wr(BREAK_ADDR, codes[i]);
            wr(CTRL_ADDR, 4'h1);
            repeat (5) @(posedge sys_clk);
            #1 chk("line during flash", 4'h0, {3'h0, line_n});
            wait_irq("flash total", codes[i] * 30 + 275, codes[i] * 30 + 315);
            chk_rng("break length", codes[i] * 30 - 12, codes[i] * 30 + 5, PARTNER.break_len);
            rchk("flash bit after irq", CTRL_ADDR, 4'h0);
            rchk("flag after flash", IRQ_FLAG_ADDR, 4'h1);
            wr(IRQ_FLAG_ADDR, 4'h1);
            rchk("flag cleared", IRQ_FLAG_ADDR, 4'h0);
            chk("irq dropped", 4'h0, {3'h0, irq});
        end
        $display("flash test done");

        wr(PINSEL_ADDR, 4'h4);
        wr(CTRL_ADDR, 4'h4);
        repeat (2) @(posedge sys_clk);
        #1 chk("hold mute", 4'h0, {3'h0, silence_n});
        chk("hold status pin", 4'h2, {2'h0, pin_two, pin_oe_n});
        wr(PORT_DATA_ADDR, 4'hB);
        repeat (2) @(posedge sys_clk);
        #1 chk("status forced low", 4'h0, {3'h0, pin_two});
        wr(PORT_DATA_ADDR, 4'hF);
        wr(CTRL_ADDR, 4'h0);
        repeat (2) @(posedge sys_clk);
        #1 chk("hold released", 4'h2, {2'h0, silence_n, pin_two});
        $display("hold test done");

        wr(IRQ_MASK_ADDR, 4'h0);
        PARTNER.end_digit(1'b0);
        repeat (60) @(posedge sys_clk);
        #1 chk("masked irq", 4'h0, {3'h0, irq});
        rchk("flag while masked", IRQ_FLAG_ADDR, 4'h1);
        wr(IRQ_FLAG_ADDR, 4'h1);
        wr(MODE_ADDR, 4'h8);
        wr(GAP_ADDR, 4'h1);
        wr(IRQ_MASK_ADDR, 4'h1);
        PARTNER.end_digit(1'b1);
        wait_irq("pulse digit gap", 18, 40);
        wr(IRQ_FLAG_ADDR, 4'h1);
        wr(MODE_ADDR, 4'h0);
        wr(PAUSE_ADDR, 4'h1);
        wr(CTRL_ADDR, 4'h2);
        wait_irq("pause time", 300, 335);
        rchk("pause bit after irq", CTRL_ADDR, 4'h0);
        $display("interrupt test done");
        test_done();
    end
endmodule : dialer_control_tb_top
